// ---- common/flash_cmd_consts.vh ----
// constants for the flash command, status and time-out block
`ifndef FLASH_CMD_CONSTS_VH
`define FLASH_CMD_CONSTS_VH

// =====================================================================
// command register fields
`define FCC_VERIFY_BIT 7
`define FCC_FAIL_BIT 5
`define FCC_SEL_HI 7
`define FCC_SEL_LO 5
`define FCC_CMD_HI 4
`define FCC_CMD_LO 0
`define FCC_CMD_RESET 5'h00
`define FCC_SEL_RESET 3'h0

// =====================================================================
// command codes (only two operations are modelled)
`define CMD_BYTE_WRITE 5'h01
`define CMD_PAGE_ERASE 5'h02

// =====================================================================
// flash array operations
`define OP_WRITE 2'h0
`define OP_ERASE 2'h1
`define OP_READ 2'h2

// =====================================================================
// timing: prescale before the tick divider, address range
`define TICK_PRESCALE 256
`define FLASH_SIZE 17'h10000

// write time-out in program ticks per selection code
`define TO_WR_0 14'd55
`define TO_WR_1 14'd60
`define TO_WR_2 14'd65
`define TO_WR_3 14'd69
`define TO_WR_4 14'd75
`define TO_WR_5 14'd80
`define TO_WR_6 14'd85
`define TO_WR_7 14'd89

// erase time-out in program ticks per selection code
`define TO_ER_0 14'd5435
`define TO_ER_1 14'd5953
`define TO_ER_2 14'd6452
`define TO_ER_3 14'd6897
`define TO_ER_4 14'd7408
`define TO_ER_5 14'd7906
`define TO_ER_6 14'd8404
`define TO_ER_7 14'd8889

`endif

// ---- hw/flash_command_status_timeout.v ----
// flash command register, operation sequencer, verify and time-out
`timescale 1ns/1ps
`include "flash_cmd_consts.vh"

// What this block does
// [R1] after each byte write, read back and compare; mismatch clears write_verify_ok
// [R2] write_verify_ok returns to 1 when a new programming command starts
// [R3] command-failed bit set when the last command did not complete correctly
// [R4] reading leaves command-failed alone; only a new command clears it
// [R5] out-of-range or protected target address fails the command
// [R6] time-out counted in program ticks of clock/256/(divider+1)
// [R7] 3-bit selection picks write and erase tick limits from a table
// [R8] software should use selection 111 in normal operation
// [R9] software should check the result after every command
// [R10] CPU is held stalled while a command executes
// [R11] reaching the tick limit ends the operation and sets command-failed
// [R12] register write loads selection from bits 7:5, code from 4:0, and starts
module flash_command_status_timeout #(
	parameter TICK_PRESCALE = `TICK_PRESCALE
)(
	input wire clk,
	input wire sys_rst,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_wdata,
	output wire [7:0] reg_rdata,
	input wire [7:0] program_tick_divider,
	input wire [16:0] target_addr,
	input wire [7:0] target_data,
	input wire addr_protected,
	output wire cpu_stall,
	output reg fl_req_ff,
	output reg [1:0] fl_op_ff,
	output reg [15:0] fl_addr_ff,
	output reg [7:0] fl_wdata_ff,
	input wire fl_ack,
	input wire [7:0] fl_rdata
);

	localparam ST_IDLE = 2'h0;
	localparam ST_EXEC = 2'h1;
	localparam ST_READ = 2'h2;
	// prescale end point, cut to the width of the prescale counter on purpose
	localparam [31:0] PRE_LAST_W = TICK_PRESCALE - 1;
	localparam [7:0] PRE_LAST = PRE_LAST_W[7:0];

	reg [1:0] state_ff;
	reg [1:0] nxt_state;
	reg [4:0] command_code_ff;
	reg [2:0] timeout_select_ff;
	reg write_verify_ok_ff;
	reg nxt_verify;
	reg fail_ff;
	reg nxt_fail;
	reg [7:0] pre_ff;
	reg [7:0] div_ff;
	reg [13:0] ticks_ff;
	reg [13:0] limit;
	reg nxt_req;
	reg [1:0] nxt_op;
	wire pre_wrap;
	wire program_tick;
	wire is_prog;
	wire bad_addr;
	wire timed_out;

	// =====================================================================
	// register view; reg_rd has no side effect on any flag
	assign reg_rdata = {write_verify_ok_ff, 1'b0, fail_ff, command_code_ff}; // [R4]
	// stall covers the write cycle itself so the CPU never sees a gap
	assign cpu_stall = reg_wr | (state_ff != ST_IDLE); // [R10]

	assign is_prog = (reg_wdata[`FCC_CMD_HI:`FCC_CMD_LO] == `CMD_BYTE_WRITE) |
		(reg_wdata[`FCC_CMD_HI:`FCC_CMD_LO] == `CMD_PAGE_ERASE);
	assign bad_addr = (target_addr >= `FLASH_SIZE) | addr_protected; // [R5]

	// =====================================================================
	// program tick: fixed prescale, then the software divider
	assign pre_wrap = (pre_ff == PRE_LAST); // [R6]
	assign program_tick = pre_wrap & (div_ff == program_tick_divider); // [R6]

	// tick base restarts with each command so every limit is measured whole
	always @(posedge clk)
	begin
		if (sys_rst | reg_wr)
		begin
			pre_ff <= 8'h00;
			div_ff <= 8'h00;
		end
		else
		begin
			pre_ff <= pre_wrap ? 8'h00 : pre_ff + 8'h01;
			if (pre_wrap)
				div_ff <= program_tick ? 8'h00 : div_ff + 8'h01;
		end
	end

	// =====================================================================
	// time-out limit table, selected by operation and selection code
	always @*
	begin
		limit = `TO_WR_7;
		if (command_code_ff == `CMD_PAGE_ERASE)
		begin
			case (timeout_select_ff) // [R7]
				3'h0: limit = `TO_ER_0;
				3'h1: limit = `TO_ER_1;
				3'h2: limit = `TO_ER_2;
				3'h3: limit = `TO_ER_3;
				3'h4: limit = `TO_ER_4;
				3'h5: limit = `TO_ER_5;
				3'h6: limit = `TO_ER_6;
				default: limit = `TO_ER_7;
			endcase
		end
		else
		begin
			case (timeout_select_ff) // [R7]
				3'h0: limit = `TO_WR_0;
				3'h1: limit = `TO_WR_1;
				3'h2: limit = `TO_WR_2;
				3'h3: limit = `TO_WR_3;
				3'h4: limit = `TO_WR_4;
				3'h5: limit = `TO_WR_5;
				3'h6: limit = `TO_WR_6;
				default: limit = `TO_WR_7;
			endcase
		end
	end

	assign timed_out = (ticks_ff >= limit); // [R11]

	// tick count, cleared at each command start
	always @(posedge clk)
	begin
		if (sys_rst | reg_wr)
			ticks_ff <= 14'h0000;
		else if ((state_ff != ST_IDLE) & program_tick & ~timed_out)
			ticks_ff <= ticks_ff + 14'h0001; // [R6]
	end

	// =====================================================================
	// sequencer: start, run, optional read-back, finish
	always @*
	begin
		nxt_state = state_ff;
		nxt_verify = write_verify_ok_ff;
		nxt_fail = fail_ff;
		nxt_req = 1'b0;
		nxt_op = fl_op_ff;
		case (state_ff)
			ST_IDLE:
			begin
				if (reg_wr)
				begin
					nxt_fail = 1'b0; // [R4]
					if (is_prog)
					begin
						nxt_verify = 1'b1; // [R2]
						if (bad_addr)
							nxt_fail = 1'b1; // [R5]
						else
						begin
							nxt_state = ST_EXEC; // [R12]
							nxt_req = 1'b1;
							nxt_op = (reg_wdata[`FCC_CMD_HI:`FCC_CMD_LO] == `CMD_PAGE_ERASE) ?
								`OP_ERASE : `OP_WRITE;
						end
					end
				end
			end
			ST_EXEC:
			begin
				if (fl_ack & (fl_op_ff == `OP_WRITE))
				begin
					nxt_state = ST_READ; // [R1]
					nxt_req = 1'b1;
					nxt_op = `OP_READ;
				end
				else if (fl_ack)
					nxt_state = ST_IDLE;
				else if (timed_out)
				begin
					nxt_state = ST_IDLE; // [R11]
					nxt_fail = 1'b1; // [R3]
				end
			end
			ST_READ:
			begin
				if (fl_ack)
				begin
					nxt_state = ST_IDLE;
					if (fl_rdata != fl_wdata_ff)
					begin
						nxt_verify = 1'b0; // [R1]
						nxt_fail = 1'b1; // [R3]
					end
				end
				else if (timed_out)
				begin
					nxt_state = ST_IDLE; // [R11]
					nxt_fail = 1'b1; // [R3]
				end
			end
			default:
				nxt_state = ST_IDLE;
		endcase
	end

	// state and status flags; only reset or a command write can clear fail
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			state_ff <= ST_IDLE;
			write_verify_ok_ff <= 1'b1;
			fail_ff <= 1'b0;
			fl_req_ff <= 1'b0;
			fl_op_ff <= `OP_WRITE;
		end
		else
		begin
			state_ff <= nxt_state;
			write_verify_ok_ff <= nxt_verify;
			fail_ff <= nxt_fail;
			fl_req_ff <= nxt_req;
			fl_op_ff <= nxt_op;
		end
	end

	// command fields and captured address/data, loaded on each command write
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			command_code_ff <= `FCC_CMD_RESET;
			timeout_select_ff <= `FCC_SEL_RESET;
			fl_addr_ff <= 16'h0000;
			fl_wdata_ff <= 8'h00;
		end
		else if (reg_wr & (state_ff == ST_IDLE))
		begin
			command_code_ff <= reg_wdata[`FCC_CMD_HI:`FCC_CMD_LO]; // [R12]
			timeout_select_ff <= reg_wdata[`FCC_SEL_HI:`FCC_SEL_LO]; // [R12]
			fl_addr_ff <= target_addr[15:0];
			fl_wdata_ff <= target_data;
		end
	end

endmodule

// ---- verification/flash_cmd_sva.sv ----
// port assertions for the flash command block
`timescale 1ns/1ps
module flash_cmd_sva (
	input wire clk,
	input wire sys_rst,
	input wire reg_wr,
	input wire [7:0] reg_wdata,
	input wire [7:0] reg_rdata,
	input wire [16:0] target_addr,
	input wire addr_protected,
	input wire cpu_stall,
	input wire fl_req_ff,
	input wire [1:0] fl_op_ff,
	input wire [7:0] fl_wdata_ff,
	input wire fl_ack,
	input wire [7:0] fl_rdata
);
	// =====
	// decode of the command being written
	wire isprog = reg_wdata[4:0] == 5'h01 || reg_wdata[4:0] == 5'h02;
	wire okad = !target_addr[16] && !addr_protected;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// a write taken while idle
	sequence go;
		reg_wr && !$past(cpu_stall);
	endsequence
	stall_on_wr_a: assert property (reg_wr |-> cpu_stall) else $error("no stall");
	code_load_a: assert property (go |=> reg_rdata[4:0] == $past(reg_wdata[4:0]))
		else $error("code not loaded");
	prog_start_a: assert property (go ##0 isprog && okad |=> fl_req_ff && reg_rdata[7]
		&& !reg_rdata[5] && fl_op_ff == {1'b0, $past(reg_wdata[1])}) else $error("bad start");
	bad_addr_a: assert property (go ##0 isprog && !okad |=> reg_rdata[5] && !fl_req_ff
		&& cpu_stall == reg_wr) else $error("bad address not failed");
	read_back_a: assert property (fl_ack && fl_op_ff == 2'h0 && cpu_stall |=> fl_req_ff
		&& fl_op_ff == 2'h2) else $error("no read back");
	verify_res_a: assert property (fl_ack && fl_op_ff == 2'h2 && cpu_stall |=> cpu_stall == reg_wr
		&& reg_rdata[7] == ($past(fl_rdata) == $past(fl_wdata_ff)) && reg_rdata[5] != reg_rdata[7])
		else $error("verify result wrong");
	erase_done_a: assert property (fl_ack && fl_op_ff == 2'h1 && cpu_stall |=> cpu_stall == reg_wr
		&& !reg_rdata[5]) else $error("erase end wrong");
	fail_hold_a: assert property (!cpu_stall && !reg_wr |=> $stable(reg_rdata))
		else $error("status moved while idle");
endmodule
bind flash_command_status_timeout flash_cmd_sva sva (.clk, .sys_rst, .reg_wr, .reg_wdata,
	.reg_rdata, .target_addr, .addr_protected, .cpu_stall, .fl_req_ff, .fl_op_ff, .fl_wdata_ff,
	.fl_ack, .fl_rdata);

// ---- verification/flash_array_model.sv ----
// flash array stand-in for the bench
`timescale 1ns/1ps
module flash_array_model (
	input wire clk,
	input wire fl_req_ff,
	input wire [1:0] fl_op_ff,
	input wire [7:0] fl_wdata_ff,
	input wire [3:0] lat,
	input wire bad,
	input wire hang,
	output reg fl_ack = 1'b0,
	output reg [7:0] fl_rdata = 8'h5a
);
	reg [7:0] mem_ff = 8'hff;
	integer cnt = -1;
	// =====
	// one ack per request after lat cycles; a hang drops it for good
	always @(posedge clk)
	begin
		fl_ack <= 1'b0;
		fl_rdata <= ~fl_rdata; // no stale data off the ack
		if (fl_req_ff)
			cnt <= lat;
		else if (cnt > 0)
			cnt <= cnt - 1;
		else if (cnt == 0)
		begin
			cnt <= -1;
			fl_ack <= !hang;
			if (fl_op_ff == 2'h2)
				fl_rdata <= mem_ff ^ {7'h0, bad};
			else
				mem_ff <= fl_op_ff[0] ? 8'hff : fl_wdata_ff;
		end
	end
endmodule

// ---- verification/test_flash_command_status_timeout.sv ----
// bench for the flash command block
`timescale 1ns/1ps
`include "flash_cmd_consts.vh"
module test_flash_command_status_timeout;
	reg clk = 0;
	reg rst = 1;
	reg wr = 0;
	reg rdst = 0;
	reg bad = 0;
	reg hang = 0;
	reg pr = 0;
	reg [7:0] wd = 0;
	reg [7:0] div = 0;
	reg [7:0] td = 0;
	reg [7:0] w = 0;
	integer lim [0:9];
	reg [16:0] ad = 0;
	reg [3:0] lat = 0;
	reg [23:0] row [0:5];
	wire [7:0] rd, fwd, frd;
	wire [15:0] fad;
	wire [1:0] op;
	wire stall, req, ack;
	integer error_cnt = 0;
	integer tests_run = 0;
	integer i, n;
	flash_command_status_timeout #(.TICK_PRESCALE(4)) dut (.clk(clk), .sys_rst(rst),
		.reg_wr(wr), .reg_rd(rdst), .reg_wdata(wd), .reg_rdata(rd), .program_tick_divider(div),
		.target_addr(ad), .target_data(td), .addr_protected(pr), .cpu_stall(stall),
		.fl_req_ff(req), .fl_op_ff(op), .fl_addr_ff(fad), .fl_wdata_ff(fwd), .fl_ack(ack),
		.fl_rdata(frd));
	flash_array_model fa (.clk(clk), .fl_req_ff(req), .fl_op_ff(op), .fl_wdata_ff(fwd),
		.lat(lat), .bad(bad), .hang(hang), .fl_ack(ack), .fl_rdata(frd));
	// =====
	// 50 ns clock and a generous hang limit
	initial
		forever #25 clk = ~clk;
	initial
	begin
		#3000000;
		error_cnt = error_cnt + 1;
		finish_test;
	end
	task chk(input [63:0] nm, input [15:0] e, input [15:0] g);
	begin
		tests_run = tests_run + 1;
		if (g !== e)
		begin
			error_cnt = error_cnt + 1;
			$display("[ERR] %0s exp %h got %h", nm, e, g);
		end
	end
	endtask
	// one write, then wait out the stall
	task cmd(input [7:0] w);
	begin
		wd = w;
		wr = 1;
		@(posedge clk) #1;
		wr = 0;
		n = 0;
		while (stall && n < 30000)
		begin
			@(posedge clk) #1;
			n = n + 1;
		end
		// one idle edge so a strobe is never lowered and raised in one step
		@(posedge clk) #1;
	end
	endtask
	task finish_test;
	begin
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	end
	endtask
	// rows: command, expected status, {out of range, protected, corrupt}
	initial
	begin
		row[0] = 24'he18100;
		row[1] = 24'he12101;
		row[2] = 24'he28200;
		row[3] = 24'he1a104;
		row[4] = 24'he2a202;
		row[5] = 24'hff9f00;
		// time-out limits: eight write selections, slow-tick write, erase
		lim[0] = `TO_WR_0;
		lim[1] = `TO_WR_1;
		lim[2] = `TO_WR_2;
		lim[3] = `TO_WR_3;
		lim[4] = `TO_WR_4;
		lim[5] = `TO_WR_5;
		lim[6] = `TO_WR_6;
		lim[7] = `TO_WR_7;
		lim[8] = `TO_WR_0;
		lim[9] = `TO_ER_0;
		repeat (16) @(posedge clk);
		#1 rst = 0;
		chk("reset", 16'h80, {8'h0, rd});
		for (i = 0; i < 6; i = i + 1)
		begin
			{ad[16], pr, bad} = row[i][2:0];
			ad[15:0] = {i[3:0], 12'h5a3};
			lat = i;
			td = i * 8'h25;
			cmd(row[i][23:16]);
			chk("status", row[i][15:8], {8'h0, rd});
			chk("addr", ad[15:0], fad);
			chk("wdata", {8'h0, td}, {8'h0, fwd});
			$display("row %0d done", i);
		end
		// fail survives a read strobe
		bad = 1;
		cmd(8'he1);
		rdst = 1;
		@(posedge clk) #1;
		rdst = 0;
		chk("rd_fail", 16'h21, {8'h0, rd});
		$display("rd_fail done");
		// time-out with no answer: every write selection, a slower tick, one erase
		bad = 0;
		hang = 1;
		for (i = 0; i < 10; i = i + 1)
		begin
			div = (i == 8) ? 8'h01 : 8'h00;
			w = (i == 9) ? 8'h02 : {i[2:0], 5'h01};
			cmd(w);
			chk("to_stat", {8'h0, 3'h5, w[4:0]}, {8'h0, rd});
			chk("to_len", 4 * (div + 1) * lim[i] + 1, n);
		end
		$display("timeout done");
		// reset in the middle of a hung write
		div = 8'h00;
		wd = 8'h01;
		wr = 1;
		@(posedge clk) #1;
		wr = 0;
		repeat (3) @(posedge clk);
		#1;
		chk("stall_on", 16'h1, {15'h0, stall});
		rst = 1;
		repeat (2) @(posedge clk);
		#1 rst = 0;
		repeat (2) @(posedge clk);
		#1;
		chk("rst_stat", 16'h80, {8'h0, rd});
		chk("stall_rs", 16'h0, {15'h0, stall});
		$display("mid reset done");
		finish_test;
	end
endmodule
